/* File: design/gpio_data_pkg.sv */
// Package for the two-port GPIO data register block.
// Assumes a single clock domain and a plain word-addressed register port.
package gpio_data_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam int ADDR_W = 32;
  localparam logic [31:0] PORT0_DATA_ADDR = 32'hFFFF0D20;
  localparam logic [31:0] PORT1_DATA_ADDR = 32'hFFFF0D30;

  // ***************************************************
  // Field layout
  // ***************************************************
  localparam int P0_PINS = 5;
  localparam int P1_PINS = 2;
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int IN_LSB = 0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam logic [4:0] P0_RESET = 5'h00;
  localparam logic [1:0] P1_RESET = 2'h0;

  // Register bus request carried as one bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Pin bundle: output value and output enable per pin
  typedef struct packed {
    logic [P0_PINS-1:0] out;
    logic [P0_PINS-1:0] oe;
  } p0_drive_t;

  typedef struct packed {
    logic [P1_PINS-1:0] out;
    logic [P1_PINS-1:0] oe;
  } p1_drive_t;

endpackage : gpio_data_pkg

/* File: design/gpio_data_regs.sv */
// Data registers of GPIO port 0 (five pins) and port 1 (two pins).
// Assumes pins are three-signal (in, out, oe) and resolved outside; bus is a one-cycle strobe port.
//
// Notes on behaviour
// - Port 0 data register is a 32-bit word at 0xFFFF0D20 covering direction, output and input.
// - Bits 28:24 pick direction of port 0 pins 4:0, one meaning output.
// - Bits 20:16 hold port 0 output values, driven onto a pin whenever it is an output.
// - Bits 4:0 read the live level of port 0 pins and ignore writes.
// - Port 1 data register is a 32-bit word at 0xFFFF0D30 covering direction, output and input.
// - Bits 25:24 pick direction of port 1 pins 1:0, one meaning output.
// - Bits 17:16 hold port 1 output values, driven onto a pin whenever it is an output.
// - Bits 1:0 read the live level of port 1 pins and ignore writes.
module gpio_data_regs
  import gpio_data_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [P0_PINS-1:0] p0_pin_in,
  output logic [P0_PINS-1:0] p0_pin_out,
  output logic [P0_PINS-1:0] p0_pin_oe,
  input wire logic [P1_PINS-1:0] p1_pin_in,
  output logic [P1_PINS-1:0] p1_pin_out,
  output logic [P1_PINS-1:0] p1_pin_oe
);

  // ***************************************************
  // Address decode
  // ***************************************************
  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    hit = (a == base);
  endfunction : hit

  bus_req_t req;
  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  logic sel0;
  logic sel1;
  assign sel0 = hit(req.addr, PORT0_DATA_ADDR);
  assign sel1 = hit(req.addr, PORT1_DATA_ADDR);

  // ***************************************************
  // Control state
  // ***************************************************
  p0_drive_t p0_reg, p0_next;
  p1_drive_t p1_reg, p1_next;

  always_comb begin
    p0_next = p0_reg;
    p1_next = p1_reg;
    if (req.wr && sel0) begin
      // Input and reserved bits of the write word are simply dropped
      p0_next.oe = req.wdata[DIR_LSB +: P0_PINS];
      p0_next.out = req.wdata[OUT_LSB +: P0_PINS];
    end
    if (req.wr && sel1) begin
      p1_next.oe = req.wdata[DIR_LSB +: P1_PINS];
      p1_next.out = req.wdata[OUT_LSB +: P1_PINS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_reg <= '{out: P0_RESET, oe: P0_RESET};
      p1_reg <= '{out: P1_RESET, oe: P1_RESET};
    end else if (clk_en) begin
      p0_reg <= p0_next;
      p1_reg <= p1_next;
    end
  end

  // Output value reaches the pin only while its direction bit is set
  assign p0_pin_out = p0_reg.out & p0_reg.oe;
  assign p0_pin_oe = p0_reg.oe;
  assign p1_pin_out = p1_reg.out & p1_reg.oe;
  assign p1_pin_oe = p1_reg.oe;

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  // Two stages guard against metastability; readback on bus_rdata lags the pin by three cycles
  logic [P0_PINS-1:0] p0_meta_reg, p0_sync_reg;
  logic [P1_PINS-1:0] p1_meta_reg, p1_sync_reg;
  logic [P0_PINS-1:0] p0_meta_next, p0_sync_next;
  logic [P1_PINS-1:0] p1_meta_next, p1_sync_next;

  always_comb begin
    p0_meta_next = p0_pin_in;
    p0_sync_next = p0_meta_reg;
    p1_meta_next = p1_pin_in;
    p1_sync_next = p1_meta_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_meta_reg <= P0_RESET;
      p0_sync_reg <= P0_RESET;
      p1_meta_reg <= P1_RESET;
      p1_sync_reg <= P1_RESET;
    end else if (clk_en) begin
      p0_meta_reg <= p0_meta_next;
      p0_sync_reg <= p0_sync_next;
      p1_meta_reg <= p1_meta_next;
      p1_sync_reg <= p1_sync_next;
    end
  end

  // ***************************************************
  // Read path
  // ***************************************************
  logic [31:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = READ_ZERO;
    if (req.rd && sel0) begin
      rdata_next[DIR_LSB +: P0_PINS] = p0_reg.oe;
      rdata_next[OUT_LSB +: P0_PINS] = p0_reg.out;
      rdata_next[IN_LSB +: P0_PINS] = p0_sync_reg;
    end else if (req.rd && sel1) begin
      rdata_next[DIR_LSB +: P1_PINS] = p1_reg.oe;
      rdata_next[OUT_LSB +: P1_PINS] = p1_reg.out;
      rdata_next[IN_LSB +: P1_PINS] = p1_sync_reg;
    end
  end

  // Read data stand for one enabled cycle only, zero otherwise and for unmapped addresses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= READ_ZERO;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ***************************************************
  // Reference copy of the control fields
  // ***************************************************
  // Decoded straight from the bus so that a slip in the main decode cannot hide itself
  logic [P0_PINS-1:0] ref_p0_dir_reg, ref_p0_dir_next;
  logic [P0_PINS-1:0] ref_p0_val_reg, ref_p0_val_next;
  logic [P1_PINS-1:0] ref_p1_dir_reg, ref_p1_dir_next;
  logic [P1_PINS-1:0] ref_p1_val_reg, ref_p1_val_next;

  always_comb begin
    ref_p0_dir_next = ref_p0_dir_reg;
    ref_p0_val_next = ref_p0_val_reg;
    ref_p1_dir_next = ref_p1_dir_reg;
    ref_p1_val_next = ref_p1_val_reg;
    if (clk_en && bus_wr && bus_addr == PORT0_DATA_ADDR) begin
      ref_p0_dir_next = bus_wdata[DIR_LSB +: P0_PINS];
      ref_p0_val_next = bus_wdata[OUT_LSB +: P0_PINS];
    end
    if (clk_en && bus_wr && bus_addr == PORT1_DATA_ADDR) begin
      ref_p1_dir_next = bus_wdata[DIR_LSB +: P1_PINS];
      ref_p1_val_next = bus_wdata[OUT_LSB +: P1_PINS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_p0_dir_reg <= P0_RESET;
      ref_p0_val_reg <= P0_RESET;
      ref_p1_dir_reg <= P1_RESET;
      ref_p1_val_reg <= P1_RESET;
    end else begin
      ref_p0_dir_reg <= ref_p0_dir_next;
      ref_p0_val_reg <= ref_p0_val_next;
      ref_p1_dir_reg <= ref_p1_dir_next;
      ref_p1_val_reg <= ref_p1_val_next;
    end
  end

  chk_p0_dir_write: assert property (clk_en && bus_wr && sel0 |=> p0_pin_oe == $past(bus_wdata[28:24]))
    else $error("port 0 direction not taken from write");
  chk_p0_out_drive: assert property (clk_en && bus_wr && sel0 |=>
      p0_pin_out == ($past(bus_wdata[20:16]) & $past(bus_wdata[28:24])))
    else $error("port 0 output value not driven");
  chk_p0_in_read: assert property (clk_en && bus_rd && sel0 |=> bus_rdata[4:0] == $past(p0_sync_reg))
    else $error("port 0 input readback wrong");
  chk_p0_reserved_zero: assert property (clk_en && bus_rd && sel0 |=>
      bus_rdata[31:29] == 3'h0 && bus_rdata[23:21] == 3'h0 && bus_rdata[15:5] == 11'h000)
    else $error("port 0 reserved bits not zero");
  chk_p1_dir_write: assert property (clk_en && bus_wr && sel1 |=> p1_pin_oe == $past(bus_wdata[25:24]))
    else $error("port 1 direction not taken from write");
  chk_p1_out_drive: assert property (clk_en && bus_wr && sel1 |=>
      p1_pin_out == ($past(bus_wdata[17:16]) & $past(bus_wdata[25:24])))
    else $error("port 1 output value not driven");
  chk_p1_in_read: assert property (clk_en && bus_rd && sel1 |=> bus_rdata[1:0] == $past(p1_sync_reg))
    else $error("port 1 input readback wrong");
  chk_p1_read_map: assert property (clk_en && bus_rd && sel1 |=>
      bus_rdata[31:26] == 6'h00 && bus_rdata[25:24] == p1_pin_oe)
    else $error("port 1 read map wrong");
  chk_sync_delay: assert property (clk_en ##1 clk_en |=> p0_sync_reg == $past(p0_pin_in, 2))
    else $error("port 0 synchroniser delay wrong");
  chk_hold_idle: assert property (!bus_wr |=> $stable(p0_pin_oe) && $stable(p1_pin_oe))
    else $error("direction changed without write");
  chk_unmapped_zero: assert property (clk_en && bus_rd && !sel0 && !sel1 |=> bus_rdata == 32'h00000000)
    else $error("unmapped read not zero");

  // ***************************************************
  // Checks on port isolation and reference copy
  // ***************************************************
  // Both ports share one decode, so a write to either must leave the other untouched
  chk_p0_ref_match: assert property (p0_pin_oe == ref_p0_dir_reg &&
      p0_pin_out == (ref_p0_val_reg & ref_p0_dir_reg))
    else $error("port 0 pins differ from reference copy");

  chk_p1_ref_match: assert property (p1_pin_oe == ref_p1_dir_reg &&
      p1_pin_out == (ref_p1_val_reg & ref_p1_dir_reg))
    else $error("port 1 pins differ from reference copy");

  chk_p0_isolation: assert property (clk_en && bus_wr && sel1 |=>
      $stable(p0_pin_oe) && $stable(p0_pin_out))
    else $error("port 1 write disturbed port 0");

  chk_p1_isolation: assert property (clk_en && bus_wr && sel0 |=>
      $stable(p1_pin_oe) && $stable(p1_pin_out))
    else $error("port 0 write disturbed port 1");

  chk_unmapped_wr_hold: assert property (clk_en && bus_wr && !sel0 && !sel1 |=>
      $stable(p0_pin_oe) && $stable(p0_pin_out) && $stable(p1_pin_oe) && $stable(p1_pin_out))
    else $error("unmapped write changed a pin");

  chk_read_no_effect: assert property (clk_en && bus_rd |=>
      $stable(p0_pin_oe) && $stable(p0_pin_out) && $stable(p1_pin_oe) && $stable(p1_pin_out))
    else $error("read changed a pin");

  // ***************************************************
  // Checks on read data
  // ***************************************************
  // Read data are zero between reads, so several slaves may share one OR-ed return path
  chk_rdata_one_cycle: assert property (clk_en && !bus_rd |=> bus_rdata == READ_ZERO)
    else $error("read data stood beyond one cycle");

  chk_write_quiet: assert property (clk_en && bus_wr |=> bus_rdata == READ_ZERO)
    else $error("write produced read data");

  chk_p0_dir_read: assert property (clk_en && bus_rd && sel0 |=>
      bus_rdata[DIR_LSB +: P0_PINS] == $past(ref_p0_dir_reg))
    else $error("port 0 direction readback wrong");

  chk_p0_out_read: assert property (clk_en && bus_rd && sel0 |=>
      bus_rdata[OUT_LSB +: P0_PINS] == $past(ref_p0_val_reg))
    else $error("port 0 output readback wrong");

  chk_p1_out_read: assert property (clk_en && bus_rd && sel1 |=>
      bus_rdata[OUT_LSB +: P1_PINS] == $past(ref_p1_val_reg))
    else $error("port 1 output readback wrong");

  chk_p1_reserved_zero: assert property (clk_en && bus_rd && sel1 |=>
      bus_rdata[23:18] == 6'h00 && bus_rdata[15:2] == 14'h0000)
    else $error("port 1 reserved bits not zero");

  // ***************************************************
  // Checks on reset, clock enable and synchronisers
  // ***************************************************
  // Reset is checked from its second edge on: the first edge may still see the power-up state
  chk_reset_clear: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |->
      p0_pin_oe == P0_RESET && p0_pin_out == P0_RESET && p1_pin_oe == P1_RESET && bus_rdata == READ_ZERO)
    else $error("reset left a pin driven or read data set");

  chk_enable_freeze: assert property (!clk_en |=>
      $stable(p0_pin_oe) && $stable(p0_pin_out) && $stable(p1_pin_oe) && $stable(p1_pin_out) &&
      $stable(bus_rdata) && $stable(p0_sync_reg) && $stable(p1_sync_reg))
    else $error("state moved while clock enable low");

  chk_p0_meta_stage: assert property (clk_en |=> p0_meta_reg == $past(p0_pin_in))
    else $error("port 0 first sync stage wrong");

  chk_p1_meta_stage: assert property (clk_en |=> p1_meta_reg == $past(p1_pin_in))
    else $error("port 1 first sync stage wrong");

  chk_p0_in_ignore: assert property (clk_en && bus_wr && sel0 |=>
      p0_sync_reg == $past(p0_meta_reg))
    else $error("port 0 write disturbed input path");

  chk_p1_in_ignore: assert property (clk_en && bus_wr && sel1 |=>
      p1_sync_reg == $past(p1_meta_reg))
    else $error("port 1 write disturbed input path");

  chk_p1_sync_delay: assert property (clk_en ##1 clk_en |=> p1_sync_reg == $past(p1_pin_in, 2))
    else $error("port 1 synchroniser delay wrong");

  cov_p0_write: cover property (clk_en && bus_wr && sel0);
  cov_p1_read: cover property (clk_en && bus_rd && sel1);
  cov_write_then_read: cover property (clk_en && bus_wr && sel0 ##1 clk_en && bus_rd && sel0);
  cov_p1_drive: cover property (p1_pin_oe == 2'h3);
  cov_unmapped_read: cover property (clk_en && bus_rd && !sel0 && !sel1);

endmodule : gpio_data_regs

/* File: test/pin_partner.sv */
// Far-side model: outside circuitry on the GPIO pins.
// Assumes the bench gives the level that outside drivers put on each pin.
module pin_partner
  import gpio_data_pkg::*;
(
  input wire logic [P0_PINS-1:0] p0_oe,
  input wire logic [P0_PINS-1:0] p0_out,
  input wire logic [P0_PINS-1:0] ext0,
  input wire logic [P1_PINS-1:0] p1_oe,
  input wire logic [P1_PINS-1:0] p1_out,
  input wire logic [P1_PINS-1:0] ext1,
  output logic [P0_PINS-1:0] p0_lvl,
  output logic [P1_PINS-1:0] p1_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside drivers yield wherever the device drives
  assign p0_lvl = (p0_oe & p0_out) | (~p0_oe & ext0);
  assign p1_lvl = (p1_oe & p1_out) | (~p1_oe & ext1);
endmodule : pin_partner

/* File: test/tb_top.sv */
// Bench for the GPIO data registers: corner and random writes, pin and readback checks.
// Assumes pin_partner resolves the pins and a 20 MHz clock.
module tb_top
  import gpio_data_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, clk_en, bus_wr, bus_rd;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, w0, w1, d;
  logic [4:0] p0_in, p0_out, p0_oe, e0;
  logic [1:0] p1_in, p1_out, p1_oe, e1;
  int mismatches, samples_checked;
  gpio_data_regs DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .p0_pin_in(p0_in),
    .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe));
  pin_partner far (.p0_oe(p0_oe), .p0_out(p0_out), .ext0(e0), .p1_oe(p1_oe), .p1_out(p1_out),
    .ext1(e1), .p0_lvl(p0_in), .p1_lvl(p1_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task conclude;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task wr(logic [31:0] a, logic [31:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  task rd(logic [31:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  // Pin level as read back: driven value where output, outside level where input
  function logic [31:0] expect_rd(logic [31:0] w, logic [31:0] m, logic [4:0] e, logic [4:0] pm);
    logic [4:0] lvl;
    lvl = ((w[28:24] & w[20:16]) | (~w[28:24] & e)) & pm;
    return (w & m) | {27'h0, lvl};
  endfunction : expect_rd
  // Two enabled edges let the synchronisers settle before readback
  task verify;
    #1;
    check("p0_oe", {27'h0, p0_oe}, {27'h0, w0[28:24]});
    check("p0_out", {27'h0, p0_out}, {27'h0, w0[20:16] & w0[28:24]});
    check("p1_oe", {30'h0, p1_oe}, {30'h0, w1[25:24]});
    check("p1_out", {30'h0, p1_out}, {30'h0, w1[17:16] & w1[25:24]});
    repeat (2) @(posedge clk);
    rd(PORT0_DATA_ADDR);
    check("port0_data", d, expect_rd(w0, 32'h1F1F0000, e0, 5'h1F));
    rd(PORT1_DATA_ADDR);
    check("port1_data", d, expect_rd(w1, 32'h03030000, {3'h0, e1}, 5'h03));
  endtask : verify
  initial begin
    void'($urandom(32'h5b9abe76));
    reset_n = 1'b0;
    clk_en = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 32'h0;
    bus_wdata = 32'h0;
    e0 = 5'h00;
    e1 = 2'h0;
    w0 = 32'h0;
    w1 = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    verify();
    // Ones into input and reserved bits must not stick
    w0 = 32'hFFFFFFFF;
    w1 = 32'hFFFFFFFF;
    wr(PORT0_DATA_ADDR, w0);
    wr(PORT1_DATA_ADDR, w1);
    verify();
    // Unmapped write and a write with the clock disabled are both ignored
    wr(32'hFFFF0D24, 32'h0);
    clk_en <= 1'b0;
    wr(PORT1_DATA_ADDR, 32'h0);
    clk_en <= 1'b1;
    verify();
    rd(32'hFFFF0D34);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      e0 <= 5'($urandom);
      e1 <= 2'($urandom);
      w0 = $urandom & 32'h1F1F0000;
      w1 = $urandom & 32'h03030000;
      wr(PORT0_DATA_ADDR, w0);
      wr(PORT1_DATA_ADDR, w1);
      verify();
    end
    // Reset in mid-run must drop every pin back to input
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    w0 = 32'h0;
    w1 = 32'h0;
    verify();
    conclude();
  end
endmodule : tb_top
